// ==== rtl/mdb_engine.sv ====
// Mixed dimming brightness engine with AXI4-Lite register access
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module mdb_engine
	import mdb_pkg::*;
#(
	parameter int CNT_W  = 16,
	parameter int MEAS_W = 24,
	parameter int CH     = 4
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// AXI4-Lite write address
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// AXI4-Lite write response
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	// AXI4-Lite read data
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// Brightness pulse input pin
	input  wire logic              brightness_pulse_input,
	// Channel drive
	output logic [CH-1:0]          sink_pwm,
	output logic [7:0]             current_gain,
	output logic                   thermal_derating_enable
);

	typedef enum logic [2:0] {ST_IDLE, ST_EXP, ST_SPLIT, ST_DIV, ST_WAIT}
		mdb_state_t;

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return a == ADDR_CFG || a == ADDR_BRIGHT_H || a == ADDR_BRIGHT_L ||
			a == ADDR_COMPUTED_GAIN_STATUS || a == ADDR_DUTY_H || a == ADDR_DUTY_L;
	endfunction : addr_mapped

	logic [1:0]          rst_sync_reg;
	logic                rst_i;
	mdb_cfg_t            cfg_reg;
	logic [7:0]          bright_h_reg;
	logic [7:0]          bright_l_reg;
	logic [ADDR_W-1:0]   aw_addr_reg;
	logic [31:0]         w_data_reg;
	logic                w_lane0_reg;
	logic                do_write;
	logic [2:0]          pin_sync_reg;
	logic                pin_level_reg;
	logic                pin_level_d_reg;
	logic [MEAS_W-1:0]   per_cnt_reg;
	logic [MEAS_W-1:0]   hi_cnt_reg;
	logic [MEAS_W-1:0]   meas_per_reg;
	logic [MEAS_W-1:0]   meas_hi_reg;
	logic                meas_start_reg;
	logic                meter_busy;
	logic                meter_done;
	logic [15:0]         meter_quot;
	logic [15:0]         meas_duty_reg;
	mdb_state_t          state_reg;
	logic [15:0]         bright_reg;
	logic [15:0]         acc_reg;
	logic [7:0]          steps_reg;
	logic [31:0]         exp_prod;
	logic [15:0]         tp_level;
	logic                mix_start_reg;
	logic                mix_done;
	logic [15:0]         mix_quot;
	mdb_result_t         pend_reg;
	mdb_result_t         act_reg;
	logic [CNT_W-1:0]    pwm_cnt_reg;
	logic                pwm_on;

	// ==========================================================
	// Reset release
	// ==========================================================
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_i = rst_sync_reg[1];

	// ==========================================================
	// AXI4-Lite write channel
	// ==========================================================
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_addr_reg   <= '0;
			w_data_reg    <= 32'h0000_0000;
			w_lane0_reg   <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg   <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (do_write) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg   <= s_axi_wdata;
				w_lane0_reg  <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end else if (do_write) begin
				s_axi_wready <= 1'b1;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_mapped(aw_addr_reg) ? RESP_OKAY
					: RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Writable registers; status words ignore writes
	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i) begin
			cfg_reg      <= CFG_RST;
			bright_h_reg <= BRIGHT_RST;
			bright_l_reg <= BRIGHT_RST;
		end else if (do_write && w_lane0_reg) begin
			unique case (aw_addr_reg)
				ADDR_CFG:      cfg_reg      <= w_data_reg[CFG_W-1:0];
				ADDR_BRIGHT_H: bright_h_reg <= w_data_reg[7:0];
				ADDR_BRIGHT_L: bright_l_reg <= w_data_reg[7:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	// ==========================================================
	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= addr_mapped(s_axi_araddr) ? RESP_OKAY
				: RESP_SLVERR;
			unique case (s_axi_araddr)
				ADDR_CFG:      s_axi_rdata <= 32'(cfg_reg);
				ADDR_BRIGHT_H: s_axi_rdata <= 32'(bright_h_reg);
				ADDR_BRIGHT_L: s_axi_rdata <= 32'(bright_l_reg);
				ADDR_COMPUTED_GAIN_STATUS: s_axi_rdata <= 32'(act_reg.gain);
				ADDR_DUTY_H:   s_axi_rdata <= 32'(act_reg.duty[15:8]);
				ADDR_DUTY_L:   s_axi_rdata <= 32'(act_reg.duty[7:0]);
				default:       s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Pulse input measurement
	// ==========================================================
	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i) begin
			pin_sync_reg    <= 3'b000;
			pin_level_reg   <= 1'b0;
			pin_level_d_reg <= 1'b0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], brightness_pulse_input};
			if (pin_sync_reg[1] == pin_sync_reg[2])
				pin_level_reg <= pin_sync_reg[2];
			pin_level_d_reg <= pin_level_reg;
		end
	end

	// Period and high time, captured at each rising edge
	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i) begin
			per_cnt_reg    <= '0;
			hi_cnt_reg     <= '0;
			meas_per_reg   <= '0;
			meas_hi_reg    <= '0;
			meas_start_reg <= 1'b0;
		end else begin
			meas_start_reg <= 1'b0;
			if (pin_level_reg && !pin_level_d_reg) begin
				meas_per_reg   <= per_cnt_reg;
				meas_hi_reg    <= hi_cnt_reg;
				meas_start_reg <= !meter_busy;
				per_cnt_reg    <= MEAS_W'(1);
				hi_cnt_reg     <= MEAS_W'(1);
			end else begin
				if (~&per_cnt_reg)
					per_cnt_reg <= per_cnt_reg + MEAS_W'(1);
				if (pin_level_reg && ~&hi_cnt_reg)
					hi_cnt_reg <= hi_cnt_reg + MEAS_W'(1);
			end
		end
	end

	mdb_divider #(.W(MEAS_W)) u_meter (
		.mclk  (mclk),
		.rst_n (rst_i),
		.start (meas_start_reg),
		.num   (meas_hi_reg),
		.den   (meas_per_reg),
		.busy  (meter_busy),
		.done  (meter_done),
		.quot  (meter_quot)
	);

	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i)
			meas_duty_reg <= 16'h0000;
		else if (meter_done)
			meas_duty_reg <= meter_quot;
	end

	// ==========================================================
	// Brightness computation
	// ==========================================================
	assign exp_prod = acc_reg * EXP_FACTOR;
	assign tp_level = 16'((cfg_reg.tpoint + 2'b01) * TP_STEP);

	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i) begin
			state_reg     <= ST_IDLE;
			bright_reg    <= 16'h0000;
			acc_reg       <= 16'h0000;
			steps_reg     <= 8'h00;
			mix_start_reg <= 1'b0;
			pend_reg      <= RESULT_RST;
		end else begin
			mix_start_reg <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (cfg_reg.exp_curve) begin
						acc_reg <= FULL16;
						// Only the low byte or top measured byte
						steps_reg <= EXP_TOP - (cfg_reg.src_reg ? bright_l_reg
							: meas_duty_reg[15:8]);
						state_reg <= ST_EXP;
					end else begin
						bright_reg <= cfg_reg.src_reg
							? {bright_h_reg, bright_l_reg}
							: meas_duty_reg;
						state_reg <= ST_SPLIT;
					end
				end
				ST_EXP: begin
					// One multiply by 0.961 per remaining step
					if (steps_reg == 8'h00) begin
						bright_reg <= acc_reg;
						state_reg  <= ST_SPLIT;
					end else begin
						acc_reg   <= exp_prod[31:16];
						steps_reg <= steps_reg - 8'h01;
					end
				end
				ST_SPLIT: begin
					if (!cfg_reg.mixed_en) begin
						pend_reg  <= '{gain: GAIN_MAX, duty: bright_reg};
						state_reg <= ST_IDLE;
					end else if (bright_reg >= tp_level) begin
						// Unity slope gain, duty full on
						pend_reg  <= '{gain: bright_reg[15:8], duty: FULL16};
						state_reg <= ST_IDLE;
					end else begin
						mix_start_reg <= 1'b1;
						state_reg     <= ST_DIV;
					end
				end
				ST_DIV: state_reg <= ST_WAIT;
				ST_WAIT: begin
					if (mix_done) begin
						// Minimum gain, duty scaled to 16 bits
						pend_reg  <= '{gain: tp_level[15:8], duty: mix_quot};
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	mdb_divider #(.W(16)) u_mixer (
		.mclk  (mclk),
		.rst_n (rst_i),
		.start (mix_start_reg),
		.num   (bright_reg),
		.den   (tp_level),
		.busy  (),
		.done  (mix_done),
		.quot  (mix_quot)
	);

	// ==========================================================
	// PWM generation and output drive
	// ==========================================================
	assign pwm_on = act_reg.duty == FULL16 ||
		pwm_cnt_reg < act_reg.duty;

	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i) begin
			pwm_cnt_reg <= '0;
			act_reg     <= RESULT_RST;
		end else begin
			pwm_cnt_reg <= pwm_cnt_reg + CNT_W'(1);
			if (&pwm_cnt_reg)
				act_reg <= pend_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_i) begin
		if (!rst_i) begin
			sink_pwm                <= '0;
			current_gain            <= 8'h00;
			thermal_derating_enable <= 1'b0;
		end else begin
			sink_pwm                <= {CH{pwm_on}};
			current_gain            <= act_reg.gain;
			thermal_derating_enable <= cfg_reg.derate_en;
		end
	end

endmodule : mdb_engine

`default_nettype wire

// ==== include/mdb_pkg.sv ====
// Package: constants, register map and carriers for the brightness engine
`default_nettype none

package mdb_pkg;

	// ==========================================================
	// Register map (byte addresses)
	// ==========================================================
	localparam int         ADDR_W        = 8;
	localparam logic [7:0] ADDR_CFG      = 8'h00;
	localparam logic [7:0] ADDR_BRIGHT_H = 8'h04;
	localparam logic [7:0] ADDR_BRIGHT_L = 8'h08;
	localparam logic [7:0] ADDR_COMPUTED_GAIN_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_DUTY_H   = 8'h10;
	localparam logic [7:0] ADDR_DUTY_L   = 8'h14;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Configuration field layout and reset values
	// ==========================================================
	localparam int         CFG_W     = 6;
	localparam logic [5:0] CFG_RST   = 6'h00;
	localparam logic [7:0] BRIGHT_RST = 8'h00;

	typedef struct packed {
		logic       exp_curve;   // bit 5
		logic       src_reg;     // bit 4
		logic       mixed_en;    // bit 3
		logic       derate_en;   // bit 2
		logic [1:0] tpoint;      // bits 1:0
	} mdb_cfg_t;

	// ==========================================================
	// Arithmetic constants
	// ==========================================================
	localparam logic [15:0] FULL16     = 16'hffff;
	localparam logic [15:0] TP_STEP    = 16'h2000;  // 12.5 % of scale
	localparam logic [15:0] EXP_FACTOR = 16'hf604;  // 0.961 in Q0.16
	localparam logic [7:0]  EXP_TOP    = 8'hff;     // Top step index
	localparam logic [7:0]  GAIN_MAX   = 8'hff;
	localparam int          QUOT_W     = 16;

	typedef struct packed {
		logic [7:0]  gain;
		logic [15:0] duty;
	} mdb_result_t;

	localparam mdb_result_t RESULT_RST = '{gain: 8'h00, duty: 16'h0000};

endpackage : mdb_pkg

`default_nettype wire

// ==== rtl/mdb_divider.sv ====
// Sequential fractional divider: quot = num * 2^16 / den, saturating
`timescale 1ns/1ps
`default_nettype none

module mdb_divider
	import mdb_pkg::*;
#(
	parameter int W = 24
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// Request
	input  wire logic              start,
	input  wire logic [W-1:0]      num,
	input  wire logic [W-1:0]      den,
	// Answer
	output logic                   busy,
	output logic                   done,
	output logic [QUOT_W-1:0]      quot
);

	logic [W:0]          rem_reg;
	logic [W-1:0]        den_reg;
	logic [4:0]          step_reg;
	logic [W:0]          shifted;

	assign shifted = {rem_reg[W-1:0], 1'b0};

	// ==========================================================
	// Restoring division, one quotient bit per cycle
	// ==========================================================
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rem_reg  <= '0;
			den_reg  <= '0;
			step_reg <= 5'h00;
			busy     <= 1'b0;
			done     <= 1'b0;
			quot     <= 16'h0000;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				if (den == '0 || num >= den) begin
					// Ratio of one or more clips to full scale
					quot <= FULL16;
					done <= 1'b1;
				end else begin
					rem_reg  <= {1'b0, num};
					den_reg  <= den;
					step_reg <= 5'(QUOT_W);
					busy     <= 1'b1;
				end
			end else if (busy) begin
				if (shifted >= {1'b0, den_reg}) begin
					rem_reg <= shifted - {1'b0, den_reg};
					quot    <= {quot[QUOT_W-2:0], 1'b1};
				end else begin
					rem_reg <= shifted;
					quot    <= {quot[QUOT_W-2:0], 1'b0};
				end
				step_reg <= step_reg - 5'h01;
				if (step_reg == 5'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule : mdb_divider

`default_nettype wire

// ==== test/mdb_engine_properties.sv ====
// Checker: bus handshake and output assertions for the brightness engine
`timescale 1ns/1ps
`default_nettype none

module mdb_engine_chk
	import mdb_pkg::*;
#(
	parameter int CH    = 4,
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic          mclk,
	input wire logic          rst_n,
	// Register bus
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic [31:0]   s_axi_rdata,
	// Channel drive
	input wire logic [CH-1:0] sink_pwm,
	input wire logic [7:0]    current_gain,
	input wire logic          thermal_derating_enable
);
	logic [16:0] gap_cnt;

	// ==========================================================
	// Cycles since the applied gain last moved
	// ==========================================================
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt <= 17'h0;
		end else if ($changed(current_gain)) begin
			gap_cnt <= 17'h0;
		end else if (!gap_cnt[16]) begin
			gap_cnt <= gap_cnt + 17'h1;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	aw_taken_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address accepted twice");
	w_taken_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("write data accepted twice");
	bresp_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	bresp_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
		else $error("bad write response code");
	read_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered in one cycle");
	rdata_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rdata_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	channels_same_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sink_pwm == {CH{sink_pwm[0]}})
		else $error("channels differ");
	gain_boundary_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(current_gain) |-> gap_cnt >= 17'((1 << CNT_W) - 1))
		else $error("gain changed inside a period");
	derate_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(thermal_derating_enable) |-> !$past(s_axi_awready, 2)
		|| !$past(s_axi_awready, 3) || !$past(s_axi_awready, 4))
		else $error("derating changed without a write");

endmodule : mdb_engine_chk

`default_nettype wire

// ==== test/mdb_pulse_src.sv ====
// Partner: source of the brightness pulse input
`timescale 1ns/1ps
`default_nettype none

module mdb_pulse_src #(
	parameter int PERIOD = 200,
	parameter int HIGH   = 50
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Pulse pin
	output logic      pulse
);
	int cnt;

	// Fixed duty square wave
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt   <= 0;
			pulse <= 1'h0;
		end else begin
			cnt   <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			pulse <= (cnt < HIGH);
		end
	end

endmodule : mdb_pulse_src

`default_nettype wire

// ==== test/mdb_engine_tb.sv ====
// Testbench: register bus scenarios for the brightness engine
`timescale 1ns/1ps
`default_nettype none

module mdb_engine_tb
	import mdb_pkg::*;
;
	logic        mclk, rst_n, pin;
	logic        awv, awrdy, wv, wrdy, bv, brdy, arv, arrdy, rv, rrdy;
	logic [7:0]  awaddr, araddr, gain;
	logic [31:0] wdat, rdat, d;
	logic [3:0]  wstb, pwm;
	logic [1:0]  bresp, rresp, r;
	logic        derate;
	int          n_mismatch, n_compared, n;
	// Short PWM counter keeps each period at a few hundred clocks
	localparam int PWM_W = 8;

	mdb_engine #(.CNT_W(PWM_W)) u_dut (.mclk(mclk), .rst_n(rst_n),
		.s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_wdata(wdat), .s_axi_wstrb(wstb), .s_axi_bvalid(bv),
		.s_axi_bready(brdy), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
		.s_axi_arready(arrdy), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .brightness_pulse_input(pin), .sink_pwm(pwm),
		.current_gain(gain), .thermal_derating_enable(derate));

	mdb_pulse_src u_src (.mclk(mclk), .rst_n(rst_n), .pulse(pin));

	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end

	// ==========================================================
	// Checking and closing
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	// ==========================================================
	// Bus tasks, response ready raised once valid is seen
	// ==========================================================
	task automatic wr(input logic [7:0] a, input logic [7:0] v,
		input logic [3:0] s, output logic [1:0] resp);
		int k;
		k = 0;
		awv    <= 1'h1;
		awaddr <= a;
		wv     <= 1'h1;
		wdat   <= {24'h0, v};
		wstb   <= s;
		resp   = 2'h3;
		while (resp === 2'h3) begin
			@(posedge mclk);
			k++;
			if (awv && awrdy) awv <= 1'h0;
			if (wv && wrdy) wv <= 1'h0;
			if (bv && brdy) begin
				resp = bresp;
				brdy <= 1'h0;
			end else if (bv) brdy <= 1'h1;
			if (k > 200) begin
				n_mismatch++;
				$display("[FAIL] %0t write not answered", $time);
				end_sim();
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] resp);
		int k;
		k = 0;
		arv    <= 1'h1;
		araddr <= a;
		resp   = 2'h3;
		while (resp === 2'h3) begin
			@(posedge mclk);
			k++;
			if (arv && arrdy) arv <= 1'h0;
			if (rv && rrdy) begin
				resp = rresp;
				v    = rdat;
				rrdy <= 1'h0;
			end else if (rv) rrdy <= 1'h1;
			if (k > 200) begin
				n_mismatch++;
				$display("[FAIL] %0t read not answered", $time);
				end_sim();
			end
		end
	endtask : rd

	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		{awv, wv, brdy, arv, rrdy} = 5'h0;
		{awaddr, araddr, wdat, wstb} = '0;
		n_mismatch = 0;
		n_compared = 0;
		rst_n = 1'h0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), d, r);
			chk(d, 32'h0, "reset value");
			chk({30'h0, r}, {30'h0, RESP_OKAY}, "read resp");
		end
		chk({28'h0, pwm}, 32'h0, "idle pwm");
		rd(8'h18, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
		wr(8'h1c, 8'h01, 4'h1, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
		wr(ADDR_CFG, 8'h04, 4'h1, r);
		repeat (4) @(posedge mclk);
		chk({31'h0, derate}, 32'h1, "derating on");
		wr(ADDR_CFG, 8'h00, 4'h0, r);
		rd(ADDR_CFG, d, r);
		chk(d, 32'h4, "strobe off write");
		wr(ADDR_COMPUTED_GAIN_STATUS, 8'h55, 4'h1, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY}, "status write resp");
		wr(ADDR_BRIGHT_H, 8'h20, 4'h1, r);
		wr(ADDR_BRIGHT_L, 8'h00, 4'h1, r);
		// Register source, mixed, 25 percent point
		wr(ADDR_CFG, 8'h19, 4'h1, r);
		repeat (4) @(posedge mclk);
		chk({31'h0, derate}, 32'h0, "derating off");
		rd(ADDR_COMPUTED_GAIN_STATUS, d, r);
		chk(d, 32'h0, "status before boundary");
		n = 0;
		while (gain === 8'h00 && n < 70000) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(n >= 70000), 32'h0, "gain wait");
		repeat (4) @(posedge mclk);
		chk({24'h0, gain}, 32'h40, "minimum gain");
		chk({28'h0, pwm}, 32'hf, "pwm on time");
		rd(ADDR_COMPUTED_GAIN_STATUS, d, r);
		chk(d, 32'h40, "gain status");
		rd(ADDR_DUTY_H, d, r);
		chk(d, 32'h80, "duty high");
		rd(ADDR_DUTY_L, d, r);
		chk(d, 32'h0, "duty low");
		// Exponential step 254 from the low byte, 50 percent point
		wr(ADDR_BRIGHT_H, 8'h12, 4'h1, r);
		wr(ADDR_BRIGHT_L, 8'hfe, 4'h1, r);
		wr(ADDR_CFG, 8'h3b, 4'h1, r);
		repeat (600) @(posedge mclk);
		chk({24'h0, gain}, 32'hf6, "one exp step");
		rd(ADDR_COMPUTED_GAIN_STATUS, d, r);
		chk(d, 32'hf6, "high byte ignored");
		rd(ADDR_DUTY_L, d, r);
		chk(d, 32'hff, "duty full on");
		// Measured 25 percent pulse duty below the 50 percent point
		wr(ADDR_CFG, 8'h0b, 4'h1, r);
		repeat (600) @(posedge mclk);
		chk({24'h0, gain}, 32'h80, "pulse source gain");
		rd(ADDR_DUTY_H, d, r);
		chk(d, 32'h80, "pulse source duty");
		// Plain register duty of one clock
		wr(ADDR_BRIGHT_H, 8'h00, 4'h1, r);
		wr(ADDR_BRIGHT_L, 8'h01, 4'h1, r);
		wr(ADDR_CFG, 8'h10, 4'h1, r);
		repeat (600) @(posedge mclk);
		chk({24'h0, gain}, 32'hff, "unmixed gain");
		rd(ADDR_DUTY_L, d, r);
		chk(d, 32'h01, "duty code one");
		n = 0;
		repeat (1 << PWM_W) begin
			@(posedge mclk);
			if (pwm === 4'hf) n++;
		end
		chk(n, 1, "one clock pulse");
		end_sim();
	end

endmodule : mdb_engine_tb

bind mdb_engine mdb_engine_chk #(.CH(CH), .CNT_W(CNT_W)) u_chk (
	.mclk(mclk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.sink_pwm(sink_pwm), .current_gain(current_gain),
	.thermal_derating_enable(thermal_derating_enable));

`default_nettype wire
